/* File: src/pmf_pkg.sv */
// ==============================================================
// How it works
// (RULE1) paged load: two cycles, address page*10H plus offset
// (RULE2) paged store: two cycles, same paged address
// (RULE3) page write: memory word to page pointer
// (RULE4) carry copy: carry to bit 0, others zero
// (RULE5) upper cause read: flags 4,7 to bits 0,1
// (RULE6) flag 4: second divider or pin, by option
// (RULE7) flag 7: second timer underflow
// (RULE8) lower cause read: flags 0-2 to bits 0-2
// (RULE9) flag 0: first divider overflow
// (RULE10) flag 1: first timer underflow
// (RULE11) flag 2: wake port signal change
// (RULE12) page read: page pointer to accumulator and memory
// (RULE13) reserved bits zero; zero flag tracks accumulator
package pmf_pkg;
  localparam int DATA_W = 4;
  localparam int ADDR_W = 7;
  localparam int MEM_WORDS = 128;
  localparam int PAGE_SHIFT = 4;
  localparam int PAGE_BITS = 3;
  localparam int CAUSE_W = 8;
  localparam int CAUSE_DIV0 = 0;
  localparam int CAUSE_TMR0 = 1;
  localparam int CAUSE_PORT = 2;
  localparam int CAUSE_DIV1_PIN = 4;
  localparam int CAUSE_TMR1 = 7;
  localparam logic [3:0] PAGE_RESET = 4'h0;
  localparam logic [3:0] RESULT_RESET = 4'h0;
  localparam logic [7:0] CAUSE_RESET = 8'h00;

  typedef enum logic [2:0] {
    PMF_OP_NONE,
    PMF_OP_LOAD,
    PMF_OP_STORE,
    PMF_OP_PAGE_WR,
    PMF_OP_CARRY,
    PMF_OP_CAUSE_HI,
    PMF_OP_CAUSE_LO,
    PMF_OP_PAGE_RD
  } pmf_op_t;

  typedef struct packed {
    logic valid;
    pmf_op_t op;
    logic [3:0] wreg;
    logic [6:0] raddr;
  } pmf_cmd_t;

  typedef struct packed {
    logic div0_ovf;
    logic tmr0_udf;
    logic port_chg;
    logic div1_ovf;
    logic wake_pin_fall;
    logic tmr1_udf;
  } pmf_wake_t;

  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [3:0] wdata;
  } pmf_mem_wr_t;
endpackage

/* File: src/pmf_mem.sv */
`timescale 1ns/1ps
// ==============================================================
// data memory with one write and two combinational reads
module pmf_mem #(
  parameter int WORDS = pmf_pkg::MEM_WORDS
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire pmf_pkg::pmf_mem_wr_t wr,
  input wire logic [6:0] ra_a,
  input wire logic [6:0] ra_b,
  output logic [3:0] rd_a,
  output logic [3:0] rd_b
);
  typedef struct packed {
    logic [WORDS-1:0][3:0] mem;
  } pmf_mem_st_t;
  pmf_mem_st_t st_reg, st_next;
  always_comb begin
    st_next = st_reg;
    if (wr.we) begin
      st_next.mem[wr.addr] = wr.wdata;
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign rd_a = st_reg.mem[ra_a];
  assign rd_b = st_reg.mem[ra_b];
endmodule

/* File: src/pmf_cause.sv */
`timescale 1ns/1ps
// ==============================================================
// sticky pause-exit cause flags; cleared here by clr
module pmf_cause #(
  parameter bit BODY_PIN = 1'b0
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic in_pause,
  input wire pmf_pkg::pmf_wake_t wake,
  input wire logic clr,
  output logic [7:0] cause
);
  typedef struct packed {
    logic [7:0] flags;
  } pmf_cause_st_t;
  pmf_cause_st_t st_reg, st_next;
  always_comb begin
    st_next = st_reg;
    if (clr) begin
      st_next.flags = pmf_pkg::CAUSE_RESET;
    end
    // set wins over clear
    if (in_pause) begin
      if (wake.div0_ovf) st_next.flags[pmf_pkg::CAUSE_DIV0] = 1'b1; // RULE9
      if (wake.tmr0_udf) st_next.flags[pmf_pkg::CAUSE_TMR0] = 1'b1; // RULE10
      if (wake.port_chg) st_next.flags[pmf_pkg::CAUSE_PORT] = 1'b1; // RULE11
      if (BODY_PIN ? wake.wake_pin_fall : wake.div1_ovf) begin
        st_next.flags[pmf_pkg::CAUSE_DIV1_PIN] = 1'b1; // RULE6
      end
      if (wake.tmr1_udf) st_next.flags[pmf_pkg::CAUSE_TMR1] = 1'b1; // RULE7
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign cause = st_reg.flags;
  chk_flag7_set: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE7
    in_pause && wake.tmr1_udf |=> cause[pmf_pkg::CAUSE_TMR1])
    else $error("timer cause not set");
  chk_flag0_set: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE9
    in_pause && wake.div0_ovf |=> cause[pmf_pkg::CAUSE_DIV0])
    else $error("divider cause not set");
  chk_flag1_set: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE10
    in_pause && wake.tmr0_udf |=> cause[pmf_pkg::CAUSE_TMR0])
    else $error("first timer cause not set");
  chk_flag2_set: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE11
    in_pause && wake.port_chg |=> cause[pmf_pkg::CAUSE_PORT])
    else $error("port cause not set");
  chk_flag4_set: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE6
    in_pause && (BODY_PIN ? wake.wake_pin_fall : wake.div1_ovf) |=>
    cause[pmf_pkg::CAUSE_DIV1_PIN])
    else $error("option cause not set");
endmodule

/* File: src/pmf_core.sv */
`timescale 1ns/1ps
// ==============================================================
// paged move and flag read execution unit
module pmf_core #(
  parameter bit BODY_PIN = 1'b0
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire pmf_pkg::pmf_cmd_t cmd,
  input wire logic carry_flag,
  input wire logic in_pause,
  input wire pmf_pkg::pmf_wake_t wake,
  input wire logic cause_clr,
  input wire logic [3:0] wreg_rdata,
  output logic busy,
  output logic done,
  output logic [3:0] arith_result_reg,
  output logic zero_flag,
  output logic [3:0] page_pointer,
  output logic wreg_we,
  output logic [3:0] wreg_waddr,
  output logic [3:0] wreg_wdata,
  output logic [3:0] wreg_raddr,
  output logic [7:0] pause_exit_cause
);
  typedef enum logic [1:0] {
    PMF_IDLE,
    PMF_LOAD2,
    PMF_STORE2
  } pmf_state_t;

  typedef struct packed {
    pmf_state_t state;
    logic [3:0] result;
    logic zflag;
    logic [3:0] page;
    logic [6:0] paddr;
    logic [3:0] wsel;
    logic busy;
    logic done;
    logic wwe;
    logic [3:0] wdata;
    logic [3:0] wraddr;
  } pmf_st_t;

  pmf_st_t st_reg, st_next;
  pmf_pkg::pmf_mem_wr_t mwr;
  logic [3:0] rdata_r, rdata_p;
  logic [7:0] cause;

  // ==============================================================
  // helpers
  function automatic logic [6:0] paged_addr(input logic [3:0] pg, input logic [3:0] off);
    paged_addr = {pg[pmf_pkg::PAGE_BITS-1:0], off}; // RULE1 RULE2
  endfunction

  function automatic logic is_zero(input logic [3:0] v);
    is_zero = (v == 4'h0); // RULE13
  endfunction

  pmf_mem u_mem (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .wr(mwr),
    .ra_a(cmd.raddr),
    .ra_b(st_reg.paddr),
    .rd_a(rdata_r),
    .rd_b(rdata_p)
  );

  pmf_cause #(.BODY_PIN(BODY_PIN)) u_cause (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_pause(in_pause),
    .wake(wake),
    .clr(cause_clr),
    .cause(cause)
  );

  // ==============================================================
  // execution
  always_comb begin
    logic [3:0] res;
    res = 4'h0;
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.wwe = 1'b0;
    mwr = '0;
    unique case (st_reg.state)
      PMF_IDLE: begin
        if (cmd.valid) begin
          unique case (cmd.op)
            pmf_pkg::PMF_OP_LOAD: begin
              st_next.paddr = paged_addr(st_reg.page, rdata_r); // RULE1
              st_next.wsel = cmd.wreg;
              st_next.busy = 1'b1;
              st_next.state = PMF_LOAD2;
            end
            pmf_pkg::PMF_OP_STORE: begin
              st_next.paddr = paged_addr(st_reg.page, rdata_r); // RULE2
              st_next.wsel = cmd.wreg;
              st_next.wraddr = cmd.wreg;
              st_next.busy = 1'b1;
              st_next.state = PMF_STORE2;
            end
            pmf_pkg::PMF_OP_PAGE_WR: begin
              st_next.page = rdata_r; // RULE3
              st_next.done = 1'b1;
            end
            pmf_pkg::PMF_OP_CARRY: begin
              res = {3'h0, carry_flag}; // RULE4
              mwr = '{we: 1'b1, addr: cmd.raddr, wdata: res};
              st_next.result = res;
              st_next.zflag = is_zero(res);
              st_next.done = 1'b1;
            end
            pmf_pkg::PMF_OP_CAUSE_HI: begin
              res = {2'h0, cause[pmf_pkg::CAUSE_TMR1], cause[pmf_pkg::CAUSE_DIV1_PIN]}; // RULE5
              mwr = '{we: 1'b1, addr: cmd.raddr, wdata: res};
              st_next.result = res;
              st_next.zflag = is_zero(res); // RULE13
              st_next.done = 1'b1;
            end
            pmf_pkg::PMF_OP_CAUSE_LO: begin
              res = {1'h0, cause[pmf_pkg::CAUSE_PORT], cause[pmf_pkg::CAUSE_TMR0],
                     cause[pmf_pkg::CAUSE_DIV0]}; // RULE8
              mwr = '{we: 1'b1, addr: cmd.raddr, wdata: res};
              st_next.result = res;
              st_next.zflag = is_zero(res); // RULE13
              st_next.done = 1'b1;
            end
            pmf_pkg::PMF_OP_PAGE_RD: begin
              res = st_reg.page; // RULE12
              mwr = '{we: 1'b1, addr: cmd.raddr, wdata: res};
              st_next.result = res;
              st_next.zflag = is_zero(res);
              st_next.done = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      PMF_LOAD2: begin
        // second machine cycle: paged word goes to the working register
        st_next.wwe = 1'b1; // RULE1
        st_next.wdata = rdata_p;
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
        st_next.state = PMF_IDLE;
      end
      PMF_STORE2: begin
        // working register read port was pointed here in cycle one
        mwr = '{we: 1'b1, addr: st_reg.paddr, wdata: wreg_rdata}; // RULE2
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
        st_next.state = PMF_IDLE;
      end
      default: begin
        // unused state code: fall back to idle rather than hang busy
        st_next.busy = 1'b0;
        st_next.state = PMF_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '{state: PMF_IDLE, result: pmf_pkg::RESULT_RESET, zflag: 1'b1,
                  page: pmf_pkg::PAGE_RESET, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy = st_reg.busy;
  assign done = st_reg.done;
  assign arith_result_reg = st_reg.result;
  assign zero_flag = st_reg.zflag;
  assign page_pointer = st_reg.page;
  assign wreg_we = st_reg.wwe;
  assign wreg_waddr = st_reg.wsel;
  assign wreg_wdata = st_reg.wdata;
  assign wreg_raddr = st_reg.wraddr;
  assign pause_exit_cause = cause;

  // ==============================================================
  // checks
  sequence s_two_cycle_op;
    cmd.valid && !busy && cmd.op inside {pmf_pkg::PMF_OP_LOAD, pmf_pkg::PMF_OP_STORE};
  endsequence

  sequence s_take_page_wr;
    cmd.valid && !busy && cmd.op == pmf_pkg::PMF_OP_PAGE_WR;
  endsequence

  chk_paged_two_cycle: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE1
    s_two_cycle_op |=> busy && !done ##1 !busy && done)
    else $error("paged op not two cycles");
  chk_load_writes_wreg: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE1
    cmd.valid && !busy && cmd.op == pmf_pkg::PMF_OP_LOAD |=> ##1 wreg_we)
    else $error("paged load missing write");
  chk_store_no_wreg: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE2
    cmd.valid && !busy && cmd.op == pmf_pkg::PMF_OP_STORE |=> ##1 !wreg_we)
    else $error("paged store wrote register");
  chk_page_write: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE3
    s_take_page_wr |=> page_pointer == $past(rdata_r) && done)
    else $error("page write wrong");
  chk_carry_copy: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE4
    cmd.valid && !busy && cmd.op == pmf_pkg::PMF_OP_CARRY |=>
    arith_result_reg == {3'h0, $past(carry_flag)} && zero_flag == !$past(carry_flag))
    else $error("carry copy wrong");
  chk_cause_hi_rsvd: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE5
    cmd.valid && !busy && cmd.op == pmf_pkg::PMF_OP_CAUSE_HI |=>
    arith_result_reg == {2'h0, $past(cause[pmf_pkg::CAUSE_TMR1]),
                         $past(cause[pmf_pkg::CAUSE_DIV1_PIN])})
    else $error("upper cause read wrong");
  chk_cause_lo_rsvd: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE8
    cmd.valid && !busy && cmd.op == pmf_pkg::PMF_OP_CAUSE_LO |=>
    arith_result_reg == {1'h0, $past(cause[2:0])})
    else $error("lower cause read wrong");
  chk_page_read: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE12
    cmd.valid && !busy && cmd.op == pmf_pkg::PMF_OP_PAGE_RD |=>
    arith_result_reg == $past(page_pointer))
    else $error("page read wrong");
  chk_zero_flag: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE13
    $changed(arith_result_reg) |-> zero_flag == (arith_result_reg == 4'h0))
    else $error("zero flag mismatch");
  // a command offered during the second cycle must leave no trace
  chk_busy_holds: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE1
    busy |=> $stable(arith_result_reg) && $stable(page_pointer))
    else $error("state changed while busy");
  chk_page_wr_keeps: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE3
    s_take_page_wr |=> $stable(arith_result_reg) && $stable(zero_flag))
    else $error("page write touched result");
endmodule

/* File: tb/pmf_tb.sv */
`timescale 1ns/1ps
// ==============================================================
// bench for the paged move and flag read unit
module tb;
  typedef struct packed {
    pmf_pkg::pmf_op_t op;
    logic [6:0] ra;
    logic [3:0] wr;
    logic cy;
    logic [3:0] res;
    logic zflag;
    logic [3:0] pg;
    logic [3:0] wv;
  } pmf_row_t;

  logic clk_sys;
  logic arst_n;
  pmf_pkg::pmf_cmd_t cmd;
  pmf_pkg::pmf_wake_t wake;
  logic carry_flag, in_pause, cause_clr, busy, done, zero_flag, wreg_we;
  logic [3:0] wreg_rdata, arith_result_reg, page_pointer, wreg_waddr, wreg_wdata, wreg_raddr;
  logic [7:0] pause_exit_cause;
  logic [7:0] pin_cause;
  logic [3:0] wr_model [16];
  int err_count;
  int checked;

  // ==============================================================
  // ordinary cases; memory is built up row by row, so order matters
  pmf_row_t rows [12] = '{
    '{pmf_pkg::PMF_OP_CARRY, 7'h05, 4'h0, 1'h1, 4'h1, 1'h0, 4'h0, 4'h0},
    '{pmf_pkg::PMF_OP_CARRY, 7'h06, 4'h0, 1'h0, 4'h0, 1'h1, 4'h0, 4'h0},
    '{pmf_pkg::PMF_OP_STORE, 7'h06, 4'h9, 1'h0, 4'h0, 1'h1, 4'h0, 4'h9},
    '{pmf_pkg::PMF_OP_PAGE_WR, 7'h00, 4'h0, 1'h0, 4'h0, 1'h1, 4'h9, 4'h0},
    '{pmf_pkg::PMF_OP_PAGE_RD, 7'h07, 4'h0, 1'h0, 4'h9, 1'h0, 4'h9, 4'h0},
    '{pmf_pkg::PMF_OP_STORE, 7'h05, 4'hc, 1'h0, 4'h9, 1'h0, 4'h9, 4'hc},
    '{pmf_pkg::PMF_OP_LOAD, 7'h05, 4'h2, 1'h0, 4'h9, 1'h0, 4'h9, 4'hc},
    '{pmf_pkg::PMF_OP_STORE, 7'h07, 4'he, 1'h0, 4'h9, 1'h0, 4'h9, 4'he},
    '{pmf_pkg::PMF_OP_LOAD, 7'h07, 4'h4, 1'h0, 4'h9, 1'h0, 4'h9, 4'he},
    '{pmf_pkg::PMF_OP_CAUSE_LO, 7'h08, 4'h0, 1'h0, 4'h0, 1'h1, 4'h9, 4'h0},
    '{pmf_pkg::PMF_OP_CAUSE_HI, 7'h08, 4'h0, 1'h1, 4'h0, 1'h1, 4'h9, 4'h0},
    '{pmf_pkg::PMF_OP_CARRY, 7'h08, 4'h0, 1'h1, 4'h1, 1'h0, 4'h9, 4'h0}
  };
  logic [3:0] lo_exp [6] = '{4'h1, 4'h2, 4'h4, 4'h0, 4'h0, 4'h0};
  logic [3:0] hi_exp [6] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h2};
  logic [7:0] cz_exp [6] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h00, 8'h80};
  logic [7:0] pz_exp [6] = '{8'h01, 8'h02, 8'h04, 8'h00, 8'h10, 8'h80};

  pmf_core uut (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .cmd(cmd),
    .carry_flag(carry_flag),
    .in_pause(in_pause),
    .wake(wake),
    .cause_clr(cause_clr),
    .wreg_rdata(wreg_rdata),
    .busy(busy),
    .done(done),
    .arith_result_reg(arith_result_reg),
    .zero_flag(zero_flag),
    .page_pointer(page_pointer),
    .wreg_we(wreg_we),
    .wreg_waddr(wreg_waddr),
    .wreg_wdata(wreg_wdata),
    .wreg_raddr(wreg_raddr),
    .pause_exit_cause(pause_exit_cause)
  );

  // second copy built for the pin option; only its cause flags are watched
  pmf_core #(.BODY_PIN(1'b1)) uut_pin (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .cmd(cmd),
    .carry_flag(carry_flag),
    .in_pause(in_pause),
    .wake(wake),
    .cause_clr(cause_clr),
    .wreg_rdata(wreg_rdata),
    .busy(),
    .done(),
    .arith_result_reg(),
    .zero_flag(),
    .page_pointer(),
    .wreg_we(),
    .wreg_waddr(),
    .wreg_wdata(),
    .wreg_raddr(),
    .pause_exit_cause(pin_cause)
  );

  // ==============================================================
  // working register file stands outside the unit
  assign wreg_rdata = wr_model[wreg_raddr];
  always @(posedge clk_sys) begin
    if (wreg_we === 1'h1) begin
      wr_model[wreg_waddr] <= wreg_wdata;
    end
  end

  // ==============================================================
  // tasks
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // a spare edge first, so valid is never dropped and raised in one step
  task automatic run(input pmf_pkg::pmf_op_t op, input logic [6:0] ra,
                     input logic [3:0] wr, output int n);
    @(posedge clk_sys);
    #1;
    cmd = '{1'h1, op, wr, ra};
    @(posedge clk_sys);
    #1;
    cmd.valid = 1'h0;
    n = 1;
    while (done !== 1'h1 && n < 6) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 6) begin
      err_count++;
      $display("[FAIL] %0t no completion", $time);
      close_out();
    end
  endtask

  initial begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ==============================================================
  // main sequence
  initial begin
    int n;
    logic ld;
    err_count = 0;
    checked = 0;
    arst_n = 1'h0;
    cmd = '0;
    carry_flag = 1'h0;
    in_pause = 1'h0;
    wake = '0;
    cause_clr = 1'h0;
    for (int i = 0; i < 16; i++) begin
      wr_model[i] = 4'(i);
    end
    repeat (12) @(posedge clk_sys);
    #1;
    chk({busy, done, page_pointer, arith_result_reg, zero_flag}, 12'h001);
    arst_n = 1'h1;
    foreach (rows[i]) begin
      carry_flag = rows[i].cy;
      ld = (rows[i].op == pmf_pkg::PMF_OP_LOAD);
      run(rows[i].op, rows[i].ra, rows[i].wr, n);
      chk(12'(n), (ld || rows[i].op == pmf_pkg::PMF_OP_STORE) ? 12'h2 : 12'h1);
      chk(arith_result_reg, rows[i].res);
      chk(zero_flag, rows[i].zflag);
      chk(page_pointer, rows[i].pg);
      chk(wreg_we, ld);
      if (ld) begin
        chk({wreg_waddr, wreg_wdata}, {rows[i].wr, rows[i].wv});
      end
      if (rows[i].op == pmf_pkg::PMF_OP_STORE) begin
        chk(wreg_raddr, rows[i].wr);
      end
    end
    // a command offered while busy must be ignored
    @(posedge clk_sys);
    #1;
    carry_flag = 1'h0;
    cmd = '{1'h1, pmf_pkg::PMF_OP_LOAD, 4'h5, 7'h07};
    @(posedge clk_sys);
    #1;
    chk(busy, 1'h1);
    cmd.op = pmf_pkg::PMF_OP_CARRY;
    @(posedge clk_sys);
    #1;
    cmd.valid = 1'h0;
    chk({done, wreg_waddr, wreg_wdata}, {1'h1, 4'h5, 4'he});
    @(posedge clk_sys);
    #1;
    chk({arith_result_reg, zero_flag}, {4'h1, 1'h0});
    // an empty op is refused: no completion, result untouched
    @(posedge clk_sys);
    #1;
    cmd = '{1'h1, pmf_pkg::PMF_OP_NONE, 4'h0, 7'h0a};
    @(posedge clk_sys);
    #1;
    cmd.valid = 1'h0;
    chk({done, busy, arith_result_reg}, {2'h0, 4'h1});
    // reset in mid-run
    arst_n = 1'h0;
    #1;
    chk({busy, done, page_pointer, arith_result_reg, zero_flag}, 12'h001);
    chk(pause_exit_cause, 8'h00);
    chk(pin_cause, 8'h00);
    @(posedge clk_sys);
    #1;
    arst_n = 1'h1;
    wake = '1;
    @(posedge clk_sys);
    #1;
    wake = '0;
    in_pause = 1'h1;
    chk(pause_exit_cause, 8'h00);
    // each wake source alone, read through both cause reads
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys);
      #1;
      wake = pmf_pkg::pmf_wake_t'(6'h20 >> i);
      @(posedge clk_sys);
      #1;
      wake = '0;
      chk(pause_exit_cause, cz_exp[i]);
      chk(pin_cause, pz_exp[i]);
      run(pmf_pkg::PMF_OP_CAUSE_LO, 7'h0a, 4'h0, n);
      chk({arith_result_reg, zero_flag}, {lo_exp[i], lo_exp[i] == 4'h0});
      run(pmf_pkg::PMF_OP_CAUSE_HI, 7'h0b, 4'h0, n);
      chk({arith_result_reg, zero_flag}, {hi_exp[i], hi_exp[i] == 4'h0});
      run(pmf_pkg::PMF_OP_PAGE_WR, 7'h0a, 4'h0, n);
      chk(page_pointer, lo_exp[i]);
      run(pmf_pkg::PMF_OP_PAGE_WR, 7'h0b, 4'h0, n);
      chk(page_pointer, hi_exp[i]);
      cause_clr = 1'h1;
      @(posedge clk_sys);
      #1;
      cause_clr = 1'h0;
    end
    // clear and a new event in one cycle: the old flag goes, the new one stays
    @(posedge clk_sys);
    #1;
    wake = pmf_pkg::pmf_wake_t'(6'h20);
    @(posedge clk_sys);
    #1;
    wake = pmf_pkg::pmf_wake_t'(6'h01);
    cause_clr = 1'h1;
    @(posedge clk_sys);
    #1;
    wake = '0;
    cause_clr = 1'h0;
    chk(pause_exit_cause, 8'h80);
    chk(pin_cause, 8'h80);
    close_out();
  end
endmodule
